// file: hdl/ivp_params.svh
// Behaviour
// - fixed priority: reset, trap, pin, timers, converter
// - converter done: flag fifteen, lowest vector
// - keypad: flag fourteen, its vector
// - serial transmit: flag thirteen, its vector
// - serial receive: flag twelve, its vector
// - serial error flag eleven; two-wire ten; nine unused
// - timer b overflow: flag eight, its vector
// - timer b channel one: flag seven
// - timer b channel zero: flag six
// - timer a overflow: flag five
// - timer a channel one: flag four
// - timer a ch0 flag three; pin flag one
// - three read-only pending status bytes, cleared on reset
`ifndef IVP_PARAMS_SVH
`define IVP_PARAMS_SVH

// ----------------------------------------
// source indices, index 0 is the highest priority
// ----------------------------------------
`define IVP_NSRC           15
`define IVP_SRC_RESET      4'h0
`define IVP_SRC_TRAP       4'h1
`define IVP_SRC_EXT_PIN    4'h2
`define IVP_SRC_TA_CH0     4'h3
`define IVP_SRC_TA_CH1     4'h4
`define IVP_SRC_TA_OVF     4'h5
`define IVP_SRC_TB_CH0     4'h6
`define IVP_SRC_TB_CH1     4'h7
`define IVP_SRC_TB_OVF     4'h8
`define IVP_SRC_TWO_WIRE   4'h9
`define IVP_SRC_SER_ERR    4'ha
`define IVP_SRC_SER_RX     4'hb
`define IVP_SRC_SER_TX     4'hc
`define IVP_SRC_KEYPAD     4'hd
`define IVP_SRC_CONV_DONE  4'he

// ----------------------------------------
// vector high-byte locations, low byte is the next address
// ----------------------------------------
`define IVP_VEC_RESET      16'hfffe
`define IVP_VEC_TRAP       16'hfffc
`define IVP_VEC_EXT_PIN    16'hfffa
`define IVP_VEC_TA_CH0     16'hfff6
`define IVP_VEC_TA_CH1     16'hfff4
`define IVP_VEC_TA_OVF     16'hfff2
`define IVP_VEC_TB_CH0     16'hfff0
`define IVP_VEC_TB_CH1     16'hffee
`define IVP_VEC_TB_OVF     16'hffec
`define IVP_VEC_TWO_WIRE   16'hffe8
`define IVP_VEC_SER_ERR    16'hffe6
`define IVP_VEC_SER_RX     16'hffe4
`define IVP_VEC_SER_TX     16'hffe2
`define IVP_VEC_KEYPAD     16'hffe0
`define IVP_VEC_CONV_DONE  16'hffde

// ----------------------------------------
// status byte locations and bit positions
// ----------------------------------------
`define IVP_STAT_A_ADDR    16'hfe04
`define IVP_STAT_B_ADDR    16'hfe05
`define IVP_STAT_C_ADDR    16'hfe06
`define IVP_STAT_RESET     8'h00
`define IVP_A_BIT_TB_CH0   7
`define IVP_A_BIT_TA_OVF   6
`define IVP_A_BIT_TA_CH1   5
`define IVP_A_BIT_TA_CH0   4
`define IVP_A_BIT_EXT_PIN  2
`define IVP_B_BIT_KEYPAD   7
`define IVP_B_BIT_SER_TX   6
`define IVP_B_BIT_SER_RX   5
`define IVP_B_BIT_SER_ERR  4
`define IVP_B_BIT_TWO_WIRE 3
`define IVP_B_BIT_TB_OVF   1
`define IVP_B_BIT_TB_CH1   0
`define IVP_C_BIT_CONV     0

// ----------------------------------------
// vector memory read latency in cycles
// ----------------------------------------
`define IVP_MEM_LATENCY    1

`endif

// file: hdl/ivp_pkg.sv
package ivp_pkg;

	// ----------------------------------------
	// fetch sequencer states, one-hot
	// ----------------------------------------
	typedef enum logic [3:0] {
		IVP_ST_IDLE   = 4'h1,
		IVP_ST_HI     = 4'h2,
		IVP_ST_LO     = 4'h4,
		IVP_ST_FINISH = 4'h8
	} ivp_state_t;

	// ----------------------------------------
	// whole state of the vector unit
	// ----------------------------------------
	typedef struct packed {
		ivp_state_t  state;
		logic [14:0] pend;
		logic [3:0]  sel;
		logic [7:0]  hi_byte;
		logic [15:0] handler;
		logic [3:0]  handler_src;
		logic        handler_valid;
		logic [7:0]  stat_a;
		logic [7:0]  stat_b;
		logic [7:0]  stat_c;
	} ivp_regs_t;

endpackage

// file: hdl/ivp_prio_pick.sv
`timescale 1ns/100ps
// ----------------------------------------
// fixed priority pick, lowest index wins
// ----------------------------------------
module ivp_prio_pick #(
	parameter int N = 15,
	parameter int W = 4
) (
	input  wire logic [N-1:0] req,
	output logic              found,
	output logic [W-1:0]      index
);
	logic [N:0]   seen;
	logic [W-1:0] idx_chain [N:0];

	assign seen[0]      = 1'b0;
	assign idx_chain[0] = '0;

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_stage
			// an earlier stage that already fired shadows every later one
			assign seen[g+1]      = seen[g] | req[g];
			assign idx_chain[g+1] = (!seen[g] && req[g]) ? W'(g) : idx_chain[g];
		end
	endgenerate

	assign found = seen[N];
	assign index = idx_chain[N];
endmodule

// file: hdl/ivp_top.sv
`timescale 1ns/100ps
`include "ivp_params.svh"

module ivp_top #(
	parameter int NSRC = `IVP_NSRC
) (
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// peripheral request levels, held by each peripheral until serviced
	input  wire logic        ext_pin_req,
	input  wire logic        timer_a_ch0_req,
	input  wire logic        timer_a_ch1_req,
	input  wire logic        timer_a_overflow_req,
	input  wire logic        timer_b_ch0_req,
	input  wire logic        timer_b_ch1_req,
	input  wire logic        timer_b_overflow_req,
	input  wire logic        two_wire_req,
	input  wire logic        serial_error_req,
	input  wire logic        serial_rx_req,
	input  wire logic        serial_tx_req,
	input  wire logic        keypad_req,
	input  wire logic        converter_done_req,
	// core side
	input  wire logic        trap_req,
	input  wire logic        int_mask,
	input  wire logic        int_take,
	output logic             int_request,
	output logic             busy,
	// vector memory read port
	output logic             mem_rd,
	output logic [15:0]      mem_addr,
	input  wire logic [7:0]  mem_rdata,
	// handler result
	output logic [15:0]      handler_addr,
	output logic [3:0]       handler_src,
	output logic             handler_valid,
	// read-only pending status bytes
	output logic [7:0]       pending_status_byte_a,
	output logic [7:0]       pending_status_byte_b,
	output logic [7:0]       pending_status_byte_c
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	ivp_pkg::ivp_regs_t r_q;
	ivp_pkg::ivp_regs_t r_d;

	logic [NSRC-1:0] req_now;
	logic [NSRC-1:0] eligible;
	logic            win_found;
	logic [3:0]      win_index;
	logic [15:0]     sel_vec;

	// ----------------------------------------
	// request gathering by source index
	// ----------------------------------------
	always_comb begin
		req_now                       = '0;
		req_now[`IVP_SRC_EXT_PIN]     = ext_pin_req;
		req_now[`IVP_SRC_TA_CH0]      = timer_a_ch0_req;
		req_now[`IVP_SRC_TA_CH1]      = timer_a_ch1_req;
		req_now[`IVP_SRC_TA_OVF]      = timer_a_overflow_req;
		req_now[`IVP_SRC_TB_CH0]      = timer_b_ch0_req;
		req_now[`IVP_SRC_TB_CH1]      = timer_b_ch1_req;
		req_now[`IVP_SRC_TB_OVF]      = timer_b_overflow_req;
		req_now[`IVP_SRC_TWO_WIRE]    = two_wire_req;
		req_now[`IVP_SRC_SER_ERR]     = serial_error_req;
		req_now[`IVP_SRC_SER_RX]      = serial_rx_req;
		req_now[`IVP_SRC_SER_TX]      = serial_tx_req;
		req_now[`IVP_SRC_KEYPAD]      = keypad_req;
		req_now[`IVP_SRC_CONV_DONE]   = converter_done_req;
	end

	// ----------------------------------------
	// eligibility: reset and trap ignore the core mask
	// ----------------------------------------
	always_comb begin
		eligible = r_q.pend;
		if (int_mask) begin
			eligible = '0;
			eligible[`IVP_SRC_RESET] = r_q.pend[`IVP_SRC_RESET];
			eligible[`IVP_SRC_TRAP]  = r_q.pend[`IVP_SRC_TRAP];
		end
	end

	ivp_prio_pick #(
		.N (NSRC),
		.W (4)
	) u_pick (
		.req   (eligible),
		.found (win_found),
		.index (win_index)
	);

	// ----------------------------------------
	// vector table
	// ----------------------------------------
	function automatic logic [15:0] vec_of(input logic [3:0] src);
		logic [15:0] v;
		v = `IVP_VEC_RESET;
		unique case (src)
			`IVP_SRC_RESET:     v = `IVP_VEC_RESET;
			`IVP_SRC_TRAP:      v = `IVP_VEC_TRAP;
			`IVP_SRC_EXT_PIN:   v = `IVP_VEC_EXT_PIN;
			`IVP_SRC_TA_CH0:    v = `IVP_VEC_TA_CH0;
			`IVP_SRC_TA_CH1:    v = `IVP_VEC_TA_CH1;
			`IVP_SRC_TA_OVF:    v = `IVP_VEC_TA_OVF;
			`IVP_SRC_TB_CH0:    v = `IVP_VEC_TB_CH0;
			`IVP_SRC_TB_CH1:    v = `IVP_VEC_TB_CH1;
			`IVP_SRC_TB_OVF:    v = `IVP_VEC_TB_OVF;
			`IVP_SRC_TWO_WIRE:  v = `IVP_VEC_TWO_WIRE;
			`IVP_SRC_SER_ERR:   v = `IVP_VEC_SER_ERR;
			`IVP_SRC_SER_RX:    v = `IVP_VEC_SER_RX;
			`IVP_SRC_SER_TX:    v = `IVP_VEC_SER_TX;
			`IVP_SRC_KEYPAD:    v = `IVP_VEC_KEYPAD;
			`IVP_SRC_CONV_DONE: v = `IVP_VEC_CONV_DONE;
			// code 4'hf has no source; falls back to the reset vector
			default:            v = `IVP_VEC_RESET;
		endcase
		return v;
	endfunction

	assign sel_vec = vec_of(r_q.sel);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		r_d               = r_q;
		r_d.handler_valid = 1'b0;

		// peripheral flags mirror the request levels; the peripheral owns the clear
		r_d.pend[NSRC-1:`IVP_SRC_EXT_PIN] = req_now[NSRC-1:`IVP_SRC_EXT_PIN];

		unique case (r_q.state)
			ivp_pkg::IVP_ST_IDLE: begin
				// only a taken request starts a fetch; reset pending starts itself
				if (win_found && (int_take || win_index == `IVP_SRC_RESET)) begin
					r_d.sel   = win_index;
					r_d.state = ivp_pkg::IVP_ST_HI;
				end
			end
			ivp_pkg::IVP_ST_HI: begin
				// high byte read issued at the even location
				r_d.state = ivp_pkg::IVP_ST_LO;
			end
			ivp_pkg::IVP_ST_LO: begin
				r_d.hi_byte = mem_rdata;
				r_d.state   = ivp_pkg::IVP_ST_FINISH;
			end
			ivp_pkg::IVP_ST_FINISH: begin
				r_d.handler       = {r_q.hi_byte, mem_rdata};
				r_d.handler_src   = r_q.sel;
				r_d.handler_valid = 1'b1;
				r_d.state         = ivp_pkg::IVP_ST_IDLE;
			end
		endcase

		// reset and trap flags are cleared by their own fetch completing
		if (r_q.state == ivp_pkg::IVP_ST_FINISH) begin
			if (r_q.sel == `IVP_SRC_RESET)
				r_d.pend[`IVP_SRC_RESET] = 1'b0;
			if (r_q.sel == `IVP_SRC_TRAP)
				r_d.pend[`IVP_SRC_TRAP] = 1'b0;
		end
		// a trap arriving on the clearing cycle is kept
		if (trap_req)
			r_d.pend[`IVP_SRC_TRAP] = 1'b1;

		// status bytes; unused positions stay zero
		r_d.stat_a = `IVP_STAT_RESET;
		r_d.stat_b = `IVP_STAT_RESET;
		r_d.stat_c = `IVP_STAT_RESET;
		r_d.stat_a[`IVP_A_BIT_TB_CH0]   = r_d.pend[`IVP_SRC_TB_CH0];
		r_d.stat_a[`IVP_A_BIT_TA_OVF]   = r_d.pend[`IVP_SRC_TA_OVF];
		r_d.stat_a[`IVP_A_BIT_TA_CH1]   = r_d.pend[`IVP_SRC_TA_CH1];
		r_d.stat_a[`IVP_A_BIT_TA_CH0]   = r_d.pend[`IVP_SRC_TA_CH0];
		r_d.stat_a[`IVP_A_BIT_EXT_PIN]  = r_d.pend[`IVP_SRC_EXT_PIN];
		r_d.stat_b[`IVP_B_BIT_KEYPAD]   = r_d.pend[`IVP_SRC_KEYPAD];
		r_d.stat_b[`IVP_B_BIT_SER_TX]   = r_d.pend[`IVP_SRC_SER_TX];
		r_d.stat_b[`IVP_B_BIT_SER_RX]   = r_d.pend[`IVP_SRC_SER_RX];
		r_d.stat_b[`IVP_B_BIT_SER_ERR]  = r_d.pend[`IVP_SRC_SER_ERR];
		r_d.stat_b[`IVP_B_BIT_TWO_WIRE] = r_d.pend[`IVP_SRC_TWO_WIRE];
		r_d.stat_b[`IVP_B_BIT_TB_OVF]   = r_d.pend[`IVP_SRC_TB_OVF];
		r_d.stat_b[`IVP_B_BIT_TB_CH1]   = r_d.pend[`IVP_SRC_TB_CH1];
		r_d.stat_c[`IVP_C_BIT_CONV]     = r_d.pend[`IVP_SRC_CONV_DONE];
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			r_q                      <= '0;
			r_q.state                <= ivp_pkg::IVP_ST_IDLE;
			// reset vector is fetched first after release
			r_q.pend[`IVP_SRC_RESET] <= 1'b1;
			r_q.sel                  <= `IVP_SRC_RESET;
			r_q.stat_a               <= `IVP_STAT_RESET;
			r_q.stat_b               <= `IVP_STAT_RESET;
			r_q.stat_c               <= `IVP_STAT_RESET;
		end else begin
			r_q <= r_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// the request is withheld for reset, which needs no grant
	assign int_request = (r_q.state == ivp_pkg::IVP_ST_IDLE) && win_found
		&& (win_index != `IVP_SRC_RESET);
	assign busy      = (r_q.state != ivp_pkg::IVP_ST_IDLE) || r_q.pend[`IVP_SRC_RESET];
	assign mem_rd    = (r_q.state == ivp_pkg::IVP_ST_HI) || (r_q.state == ivp_pkg::IVP_ST_LO);
	assign mem_addr  = (r_q.state == ivp_pkg::IVP_ST_LO) ? (sel_vec | 16'h0001) : sel_vec;

	assign handler_addr          = r_q.handler;
	assign handler_src           = r_q.handler_src;
	assign handler_valid         = r_q.handler_valid;
	assign pending_status_byte_a = r_q.stat_a;
	assign pending_status_byte_b = r_q.stat_b;
	assign pending_status_byte_c = r_q.stat_c;

endmodule

// file: verif/ivp_checker.sv
`timescale 1ns/100ps
// ----------------------------------------
// vector fetch checks
// ----------------------------------------
module ivp_checker #(
	parameter int NSRC = 15
) (
	input wire logic        clock,
	input wire logic        sys_rst,
	input wire logic        ext_pin_req,
	input wire logic        timer_a_ch0_req,
	input wire logic        timer_a_ch1_req,
	input wire logic        timer_a_overflow_req,
	input wire logic        timer_b_ch0_req,
	input wire logic        timer_b_ch1_req,
	input wire logic        timer_b_overflow_req,
	input wire logic        two_wire_req,
	input wire logic        serial_error_req,
	input wire logic        serial_rx_req,
	input wire logic        serial_tx_req,
	input wire logic        keypad_req,
	input wire logic        converter_done_req,
	input wire logic        int_mask,
	input wire logic        int_take,
	input wire logic        int_request,
	input wire logic        busy,
	input wire logic        mem_rd,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0]  mem_rdata,
	input wire logic [15:0] handler_addr,
	input wire logic [3:0]  handler_src,
	input wire logic        handler_valid,
	input wire logic [7:0]  pending_status_byte_a,
	input wire logic [7:0]  pending_status_byte_b,
	input wire logic [7:0]  pending_status_byte_c
);
	// vectors fall in three runs of even addresses, gaps at the unused flags
	function automatic logic [15:0] vec_of(logic [3:0] s);
		if (s < 4'h3) return 16'hfffe - {11'h0, s, 1'b0};
		if (s < 4'h9) return 16'hfff6 - {11'h0, s - 4'h3, 1'b0};
		return 16'hffe8 - {11'h0, s - 4'h9, 1'b0};
	endfunction

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	property p_take;
		int_request && int_take |=> mem_rd && busy && !mem_addr[0] ##1 mem_rd ##1 !mem_rd
			##1 handler_valid;
	endproperty
	a_take: assert property (p_take) else $error("grant did not give a timely fetch");
	property p_pair;
		mem_rd && !mem_addr[0] |=> mem_rd && mem_addr == $past(mem_addr) + 16'h1;
	endproperty
	a_pair: assert property (p_pair) else $error("low byte not read after high");
	property p_form;
		handler_valid |-> handler_addr == {$past(mem_rdata, 2), $past(mem_rdata)};
	endproperty
	a_form: assert property (p_form) else $error("handler address not formed");
	property p_vec;
		handler_valid |-> $past(mem_addr, 3) == vec_of(handler_src);
	endproperty
	a_vec: assert property (p_vec) else $error("wrong vector for source");
	property p_stat_a;
		!$past(sys_rst) && !$past(sys_rst, 2) |-> pending_status_byte_a == {$past(timer_b_ch0_req),
			$past(timer_a_overflow_req), $past(timer_a_ch1_req), $past(timer_a_ch0_req), 1'b0,
			$past(ext_pin_req), 2'b00};
	endproperty
	a_stat_a: assert property (p_stat_a) else $error("status byte a wrong");
	property p_stat_b;
		!$past(sys_rst) && !$past(sys_rst, 2) |-> pending_status_byte_b == {$past(keypad_req),
			$past(serial_tx_req), $past(serial_rx_req), $past(serial_error_req),
			$past(two_wire_req), 1'b0, $past(timer_b_overflow_req), $past(timer_b_ch1_req)};
	endproperty
	a_stat_b: assert property (p_stat_b) else $error("status byte b wrong");
	property p_stat_c;
		!$past(sys_rst) && !$past(sys_rst, 2) |->
			pending_status_byte_c == {7'h00, $past(converter_done_req)};
	endproperty
	a_stat_c: assert property (p_stat_c) else $error("status byte c wrong");
	property p_rst;
		$fell(sys_rst) |-> busy && !int_request && !handler_valid && pending_status_byte_a == 8'h00
			&& pending_status_byte_b == 8'h00 && pending_status_byte_c == 8'h00;
	endproperty
	a_rst: assert property (p_rst) else $error("state not cleared by reset");
	property p_done;
		handler_valid |-> !busy && !mem_rd;
	endproperty
	a_done: assert property (p_done) else $error("fetch unit not idle at completion");
	property p_req_idle;
		busy |-> !int_request;
	endproperty
	a_req_idle: assert property (p_req_idle) else $error("request raised while fetching");

	c_trap: cover property (handler_valid && handler_src == 4'h1);
	c_conv: cover property (handler_valid && handler_src == 4'he);
	c_mask: cover property (int_mask && int_take && int_request);
endmodule

// file: verif/ivp_vec_mem.sv
`timescale 1ns/100ps
// ----------------------------------------
// vector memory, one cycle read latency
// ----------------------------------------
module ivp_vec_mem (
	input wire logic        clock,
	input wire logic        mem_rd,
	input wire logic [15:0] mem_addr,
	output logic [7:0]      mem_rdata
);
	initial mem_rdata = 8'h00;
	// contents scramble the address so high and low bytes always differ
	always @(posedge clock) begin
		if (mem_rd) begin
			mem_rdata <= mem_addr[7:0] ^ 8'h3c;
		end else begin
			mem_rdata <= ~mem_rdata; // no stale byte outside a read
		end
	end
endmodule

// file: verif/testbench.sv
`timescale 1ns/100ps
module testbench;
	logic        clock = 1'b0;
	logic        sys_rst = 1'b1;
	logic [14:0] req = 15'h0000;
	logic        int_mask = 1'b0;
	logic        int_take = 1'b0;
	logic        int_request, busy, mem_rd, handler_valid;
	logic [15:0] mem_addr, handler_addr;
	logic [7:0]  mem_rdata, stat_a, stat_b, stat_c;
	logic [3:0]  handler_src;
	int          n_fail = 0;
	int          cmp_count = 0;
	int          pos [15] = '{0, 0, 2, 4, 5, 6, 7, 8, 9, 11, 12, 13, 14, 15, 16};

	always #2.5 clock = ~clock;

	ivp_top i_ivp_top (.clock(clock), .sys_rst(sys_rst), .ext_pin_req(req[2]),
		.timer_a_ch0_req(req[3]), .timer_a_ch1_req(req[4]), .timer_a_overflow_req(req[5]),
		.timer_b_ch0_req(req[6]), .timer_b_ch1_req(req[7]), .timer_b_overflow_req(req[8]),
		.two_wire_req(req[9]), .serial_error_req(req[10]), .serial_rx_req(req[11]),
		.serial_tx_req(req[12]), .keypad_req(req[13]), .converter_done_req(req[14]),
		.trap_req(req[1]), .int_mask(int_mask), .int_take(int_take), .int_request(int_request),
		.busy(busy), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
		.handler_addr(handler_addr), .handler_src(handler_src), .handler_valid(handler_valid),
		.pending_status_byte_a(stat_a), .pending_status_byte_b(stat_b),
		.pending_status_byte_c(stat_c));
	ivp_vec_mem i_ivp_vec_mem (.clock(clock), .mem_rd(mem_rd), .mem_addr(mem_addr),
		.mem_rdata(mem_rdata));

	function automatic logic [15:0] exp_addr(logic [3:0] s);
		logic [15:0] v;
		v = (s < 4'h3) ? 16'hfffe - {11'h0, s, 1'b0} : (s < 4'h9) ?
			16'hfff6 - {11'h0, s - 4'h3, 1'b0} : 16'hffe8 - {11'h0, s - 4'h9, 1'b0};
		return {v[7:0] ^ 8'h3c, (v[7:0] + 8'h01) ^ 8'h3c};
	endfunction

	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic stop_test();
		$display("mismatches %0d comparisons %0d", n_fail, cmp_count);
		if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic wait_done(input logic [3:0] s);
		int k;
		k = 0;
		do begin
			@(negedge clock);
			k++;
		end while (handler_valid !== 1'b1 && k < 12);
		chk("handler_valid", 1'b1, handler_valid);
		chk("handler_src", s, handler_src);
		chk("handler_addr", exp_addr(s), handler_addr);
	endtask

	task automatic serve(input logic [3:0] s);
		int k;
		k = 0;
		// look at the request away from the edge that updates it
		do begin
			@(negedge clock);
			k++;
		end while (int_request !== 1'b1 && k < 20);
		chk("int_request", 1'b1, int_request);
		@(posedge clock);
		int_take <= 1'b1;
		@(posedge clock);
		int_take <= 1'b0;
		wait_done(s);
	endtask

	task automatic t_reset();
		repeat (19) @(posedge clock);
		#1 chk("status in reset", 24'h0, {stat_c, stat_b, stat_a});
		@(posedge clock);
		sys_rst <= 1'b0;
		wait_done(4'h0);
	endtask

	// one source at a time: its flag, its vector
	task automatic t_each();
		for (int s = 2; s < 15; s++) begin
			@(posedge clock);
			req[s] <= 1'b1;
			repeat (2) @(posedge clock);
			#1 chk("status", 24'h1 << pos[s], {stat_c, stat_b, stat_a});
			chk("int_request", 1'b1, int_request);
			serve(4'(s));
			@(posedge clock);
			req[s] <= 1'b0;
			repeat (2) @(posedge clock);
		end
	endtask

	// everything pending: served strictly in priority order
	task automatic t_prio();
		@(posedge clock);
		req <= 15'h7ffe;
		@(posedge clock);
		req[1] <= 1'b0;
		for (int s = 1; s < 15; s++) begin
			serve(4'(s));
			@(posedge clock);
			req[s] <= 1'b0;
			repeat (2) @(posedge clock);
		end
	endtask

	// mask holds peripherals back but not the trap; reset in mid-run
	task automatic t_mask();
		@(posedge clock);
		int_mask <= 1'b1;
		req[13] <= 1'b1;
		repeat (4) @(posedge clock);
		#1 chk("masked int_request", 1'b0, int_request);
		chk("masked status", 8'h80, stat_b);
		@(posedge clock);
		req[1] <= 1'b1;
		@(posedge clock);
		req[1] <= 1'b0;
		serve(4'h1);
		@(posedge clock);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		#1 chk("status after reset", 24'h0, {stat_c, stat_b, stat_a});
		@(posedge clock);
		sys_rst <= 1'b0;
		int_mask <= 1'b0;
		wait_done(4'h0);
		serve(4'hd);
		@(posedge clock);
		req[13] <= 1'b0;
	endtask

	initial begin
		t_reset();
		t_each();
		t_prio();
		t_mask();
		stop_test();
	end

	initial begin
		repeat (20000) @(posedge clock);
		n_fail++;
		stop_test();
	end
endmodule

bind ivp_top ivp_checker #(.NSRC(NSRC)) i_ivp_checker (.clock(clock), .sys_rst(sys_rst),
	.ext_pin_req(ext_pin_req), .timer_a_ch0_req(timer_a_ch0_req),
	.timer_a_ch1_req(timer_a_ch1_req), .timer_a_overflow_req(timer_a_overflow_req),
	.timer_b_ch0_req(timer_b_ch0_req), .timer_b_ch1_req(timer_b_ch1_req),
	.timer_b_overflow_req(timer_b_overflow_req), .two_wire_req(two_wire_req),
	.serial_error_req(serial_error_req), .serial_rx_req(serial_rx_req),
	.serial_tx_req(serial_tx_req), .keypad_req(keypad_req),
	.converter_done_req(converter_done_req), .int_mask(int_mask), .int_take(int_take),
	.int_request(int_request), .busy(busy), .mem_rd(mem_rd), .mem_addr(mem_addr),
	.mem_rdata(mem_rdata), .handler_addr(handler_addr), .handler_src(handler_src),
	.handler_valid(handler_valid), .pending_status_byte_a(pending_status_byte_a),
	.pending_status_byte_b(pending_status_byte_b),
	.pending_status_byte_c(pending_status_byte_c));
